// *** design/por_seq_pkg.sv ***
// constants and carrier types for the power-on reset sequencer
// assumes a single 40 MHz clock and comparator flags already synchronous
//
// Contract
// [R1] standby reset low while standby rail low
// [R2] standby reset held 180 ms after rail good
// [R3] main reset low while main rail low
// [R4] main reset held 180 ms after rail good
// [R5] main reset waits 180 ms after standby release
// [R6] main reset pin also accepts external low
// [R7] diode cathode high at power-on enters test
// [R8] rail dip during hold restarts full hold
package por_seq_pkg;

  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned HOLD_MS      = 180;
  // 180 ms at 40 MHz, well above 4096 cycles, so the top takes it as a parameter default
  localparam int unsigned HOLD_CYCLES  = (CLK_HZ / 1000) * HOLD_MS;
  localparam int unsigned CNT_W        = 23;

  // one hold channel: counter plus released flag
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             released;
  } hold_state_t;

  // top-level state: strap capture plus good-run counters for the length checks
  typedef struct packed {
    logic             sampled;
    logic             test_mode;
    logic [CNT_W-1:0] stby_run;
    logic [CNT_W-1:0] main_run;
  } top_state_t;

endpackage : por_seq_pkg

// *** design/power_on_reset_sequencer.sv ***
// power-on reset sequencer: standby and main reset outputs, test mode entry
// assumes rail comparator flags are synchronous to CLK; main reset pin is open drain
`timescale 1ns/1ps
module power_on_reset_sequencer #(
  parameter int unsigned HOLD = por_seq_pkg::HOLD_CYCLES
) (
  // clock and asynchronous reset
  input  wire logic CLK,
  input  wire logic RST_N,
  // rail comparator results, high while the rail is above threshold
  input  wire logic STANDBY_RAIL_GOOD,
  input  wire logic MAIN_RAIL_GOOD,
  // open-drain main reset pin: sensed level, data and enable
  input  wire logic MAIN_RESET_IO_I,
  output logic      MAIN_RESET_IO_O,
  output logic      MAIN_RESET_IO_OE,
  // standby reset and the spare cathode output
  output logic      STANDBY_RESET_OUT_N,
  output logic      REMOTE_DIODE_ONE_CATHODE_I_UNUSED,
  // test strap and the resulting test mode flag
  input  wire logic REMOTE_DIODE_ONE_CATHODE,
  output logic      NAND_TEST_MODE
);

  por_seq_pkg::top_state_t state_q;
  por_seq_pkg::top_state_t state_d;
  logic stby_rel;
  logic main_rel;
  logic main_good;

  // standby channel timed straight from its comparator
  reset_hold_timer #(.HOLD(HOLD)) u_stby (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .good     (STANDBY_RAIL_GOOD), // [R1] [R2] [R8]
    .released (stby_rel)
  );

  // main hold starts only once both the main rail is good and standby released,
  // which covers both the plain case and the ordered case with one counter
  assign main_good = MAIN_RAIL_GOOD && stby_rel; // [R3] [R4] [R5]

  // main channel: same timer, fed by the gated good
  reset_hold_timer #(.HOLD(HOLD)) u_main (
    .CLK      (CLK),
    .RST_N    (RST_N),
    .good     (main_good),
    .released (main_rel)
  );

  // standby output straight from the timer flop, low until released
  assign STANDBY_RESET_OUT_N = stby_rel; // [R1]
  // open drain main pin: data fixed low, enable pulls it low while held;
  // released means floating, so an outside party can still pull it low
  assign MAIN_RESET_IO_O     = 1'b0;
  assign MAIN_RESET_IO_OE    = !main_rel; // [R3]
  // spare output kept quiet
  assign REMOTE_DIODE_ONE_CATHODE_I_UNUSED = 1'b0;

  // test strap caught once, on the first clock after reset release; later
  // changes on the cathode pin are ordinary diode traffic and are ignored
  always_comb begin
    state_d = state_q;
    if (!state_q.sampled) begin
      state_d.sampled   = 1'b1;
      state_d.test_mode = REMOTE_DIODE_ONE_CATHODE; // [R7]
    end
    // good-run lengths, saturating at one full hold; they only feed the
    // length checks below, two counters bought for an independent check
    if (!STANDBY_RAIL_GOOD) begin
      state_d.stby_run = '0;
    end else if (state_q.stby_run != por_seq_pkg::CNT_W'(HOLD)) begin
      state_d.stby_run = state_q.stby_run + 1'b1;
    end
    if (!main_good) begin
      state_d.main_run = '0;
    end else if (state_q.main_run != por_seq_pkg::CNT_W'(HOLD)) begin
      state_d.main_run = state_q.main_run + 1'b1;
    end
  end

  // all top state in one register; reset clears the strap so power-on samples again
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // external low on the main pin is accepted as a system reset; the
  // composite level is what the rest of the chip sees
  assign NAND_TEST_MODE = state_q.test_mode && MAIN_RESET_IO_I; // [R6]

  // checks on the outputs and the local state, all on CLK, quiet in reset;
  // the timers register their inputs, so most effects show one edge later
  // than the comparator change that causes them

  // standby output follows its rail down on the next edge
  stby_low_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R1]
    !STANDBY_RAIL_GOOD |=> !STANDBY_RESET_OUT_N)
    else $error("standby reset released with rail low");

  // a released standby output implies the rail was good one edge before
  stby_good_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R1]
    STANDBY_RESET_OUT_N |-> $past(STANDBY_RAIL_GOOD))
    else $error("standby released after bad rail");

  // release needs the rail good two edges back
  stby_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R2]
    $rose(STANDBY_RESET_OUT_N) |-> $past(STANDBY_RAIL_GOOD, 2))
    else $error("standby hold too short");

  // released exactly when a full hold of good cycles has been seen
  stby_len_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R2]
    STANDBY_RESET_OUT_N == (state_q.stby_run == por_seq_pkg::CNT_W'(HOLD)))
    else $error("standby hold length wrong");

  // a fresh rail rise never releases at once
  stby_wait_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R2]
    $rose(STANDBY_RAIL_GOOD) |-> !STANDBY_RESET_OUT_N ##1 !STANDBY_RESET_OUT_N)
    else $error("standby released on rail rise");

  // main output follows its rail down on the next edge
  main_low_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R3]
    !MAIN_RAIL_GOOD |=> MAIN_RESET_IO_OE)
    else $error("main reset released with rail low");

  // a released main output implies the rail was good one edge before
  main_good_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R3]
    !MAIN_RESET_IO_OE |-> $past(MAIN_RAIL_GOOD))
    else $error("main released after bad rail");

  // release needs the main rail good two edges back
  main_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R4]
    $fell(MAIN_RESET_IO_OE) |-> $past(MAIN_RAIL_GOOD, 2) && $past(STANDBY_RESET_OUT_N))
    else $error("main hold too short");

  // main released exactly after a full hold of gated good cycles
  main_len_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R4]
    !MAIN_RESET_IO_OE == (state_q.main_run == por_seq_pkg::CNT_W'(HOLD)))
    else $error("main hold length wrong");

  // a fresh main rail rise never releases at once
  main_wait_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R4]
    $rose(MAIN_RAIL_GOOD) |-> MAIN_RESET_IO_OE ##1 MAIN_RESET_IO_OE)
    else $error("main released on rail rise");

  // standby held means main held from the next edge on
  main_order_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R5]
    !STANDBY_RESET_OUT_N |=> MAIN_RESET_IO_OE)
    else $error("main released before standby");

  // main release only while standby was already released
  main_after_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R5]
    !MAIN_RESET_IO_OE |-> $past(STANDBY_RESET_OUT_N))
    else $error("main released without standby");

  // standby falling pulls main back into reset
  stby_drop_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R5]
    $fell(STANDBY_RESET_OUT_N) |=> MAIN_RESET_IO_OE)
    else $error("main kept released after standby drop");

  // main hold starts only once standby has been released
  main_rise_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R5]
    $rose(STANDBY_RESET_OUT_N) |-> MAIN_RESET_IO_OE ##1 MAIN_RESET_IO_OE)
    else $error("main released with standby");

  // the main pin is never driven high
  od_drive_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R6]
    MAIN_RESET_IO_O == 1'b0)
    else $error("main pin driven high");

  // an outside low on the main pin is seen as reset
  ext_gate_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R6]
    !MAIN_RESET_IO_I |-> !NAND_TEST_MODE)
    else $error("external reset ignored");

  // strap taken on the first edge after reset
  strap_take_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R7]
    !state_q.sampled |=> state_q.sampled && state_q.test_mode == $past(REMOTE_DIODE_ONE_CATHODE))
    else $error("strap not taken at power-on");

  // once taken, the strap value stays
  strap_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R7]
    state_q.sampled |=> $stable(state_q.test_mode))
    else $error("test mode changed after power-on");

  // no test mode before the strap has been taken
  strap_low_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R7]
    !state_q.sampled |-> !NAND_TEST_MODE)
    else $error("test mode before strap taken");

  // a standby dip keeps the reset asserted
  stby_dip_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R8]
    $fell(STANDBY_RAIL_GOOD) |=> !STANDBY_RESET_OUT_N [*2])
    else $error("standby dip not held");

  // a main dip keeps the reset asserted
  main_dip_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R8]
    $fell(MAIN_RAIL_GOOD) |=> MAIN_RESET_IO_OE [*2])
    else $error("main dip not held");

  // scenarios that should be reached by any useful run

  // standby channel completes a hold
  stby_rel_c: cover property (@(posedge CLK) disable iff (!RST_N)
    $rose(STANDBY_RESET_OUT_N));
  // main channel completes a hold
  main_rel_c: cover property (@(posedge CLK) disable iff (!RST_N)
    $fell(MAIN_RESET_IO_OE));
  // rail dips in the middle of a standby hold
  dip_c: cover property (@(posedge CLK) disable iff (!RST_N)
    !STANDBY_RESET_OUT_N && STANDBY_RAIL_GOOD ##1 !STANDBY_RAIL_GOOD);
  // test mode entered from the strap
  test_c: cover property (@(posedge CLK) disable iff (!RST_N)
    state_q.test_mode);
  // outside party pulls the main pin while the device has let go
  ext_c: cover property (@(posedge CLK) disable iff (!RST_N)
    !MAIN_RESET_IO_I && !MAIN_RESET_IO_OE);

endmodule : power_on_reset_sequencer

// *** design/reset_hold_timer.sv ***
// one reset channel: asserted while its condition is bad, released after a full hold
// assumes the good input is synchronous to CLK
`timescale 1ns/1ps
module reset_hold_timer #(
  parameter int unsigned HOLD = por_seq_pkg::HOLD_CYCLES
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic good,
  output logic      released
);

  por_seq_pkg::hold_state_t state_q;
  por_seq_pkg::hold_state_t state_d;

  // any bad cycle clears the count, so a dip restarts the whole hold
  always_comb begin
    state_d = state_q;
    if (!good) begin
      state_d.cnt      = '0;
      state_d.released = 1'b0;
    end else if (!state_q.released) begin
      if (state_q.cnt == por_seq_pkg::CNT_W'(HOLD - 1)) begin
        state_d.released = 1'b1;
      end else begin
        state_d.cnt = state_q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign released = state_q.released;

  // released never rises unless good held for the whole count
  hold_gate_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R2] [R4]
    $rose(released) |-> $past(good) && $past(state_q.cnt) == por_seq_pkg::CNT_W'(HOLD - 1))
    else $error("release without full hold");
  drop_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // [R8]
    !good |=> !released && state_q.cnt == '0)
    else $error("bad input did not restart hold");

endmodule : reset_hold_timer

// *** verif/host_reset_model.sv ***
// host side of the main reset pin: pull-up wire plus an external reset source
// assumes open-drain enable from the sequencer; high enable pulls the pin low
`timescale 1ns/1ps
module host_reset_model (
  input  wire logic drv_en,
  input  wire logic ext_low,
  output logic      pin_level
);
  // weak pull-up wins only while nobody pulls low
  assign pin_level = (drv_en || ext_low) ? 1'b0 : 1'b1;
endmodule : host_reset_model

// *** verif/power_on_reset_sequencer_tb.sv ***
// bench for the power-on reset sequencer, hold shortened to 10 cycles
// assumes release on the hold-th edge that samples the good input high
`timescale 1ns/1ps
module power_on_reset_sequencer_tb;
  logic clk, rst_n, stby, main, ext_low, strap, pin, oe, stby_n, test, pin_o, spare;
  int   fail_count, num_checks;
  // rows: {standby good, main good, expected standby_n, expected oe}
  logic [3:0] rows [8] = '{4'h5, 4'hd, 4'hf, 4'hf, 4'he, 4'hb, 4'he, 4'h5};
  int         waits[8] = '{20, 9, 1, 9, 1, 2, 10, 2};

  power_on_reset_sequencer #(.HOLD(10)) i_dut (.CLK(clk), .RST_N(rst_n), .STANDBY_RAIL_GOOD(stby),
    .MAIN_RAIL_GOOD(main), .MAIN_RESET_IO_I(pin), .MAIN_RESET_IO_O(pin_o), .MAIN_RESET_IO_OE(oe),
    .STANDBY_RESET_OUT_N(stby_n), .REMOTE_DIODE_ONE_CATHODE_I_UNUSED(spare), .REMOTE_DIODE_ONE_CATHODE(strap),
    .NAND_TEST_MODE(test));
  host_reset_model i_host (.drv_en(oe), .ext_low(ext_low), .pin_level(pin));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %b want %b", $time, got, exp);
    end
  endtask : chk

  // inputs change 1 ns after the edge, so outputs are settled there
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : edges

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // watchdog so a stuck run still reports
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    stop_test();
  end

  initial begin
    rst_n = 1'b0; stby = 1'b0; main = 1'b0; ext_low = 1'b0; strap = 1'b0;
    edges(2);
    chk(stby_n, 1'b0);
    chk(oe, 1'b1);
    chk(test, 1'b0);
    chk(pin_o, 1'b0);
    chk(spare, 1'b0);
    $display("test reset done");
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {stby, main} = rows[i][3:2];
      edges(waits[i]);
      chk(stby_n, rows[i][1]);
      chk(oe, rows[i][0]);
    end
    chk(test, 1'b0);
    $display("test rows done");
    // dip mid-hold must restart the whole count
    stby = 1'b1; edges(5); stby = 1'b0; edges(1); stby = 1'b1; edges(9);
    chk(stby_n, 1'b0);
    edges(1);
    chk(stby_n, 1'b1);
    $display("test dip done");
    // strap high at power-on, dropped later: mode must stay latched
    rst_n = 1'b0; strap = 1'b1; edges(1);
    chk(stby_n, 1'b0);
    chk(oe, 1'b1);
    rst_n = 1'b1; edges(2); strap = 1'b0; edges(17);
    chk(oe, 1'b1);
    edges(1);
    chk(oe, 1'b0);
    chk(test, 1'b1);
    ext_low = 1'b1; edges(1);
    chk(pin, 1'b0);
    chk(test, 1'b0);
    chk(oe, 1'b0);
    chk(pin_o, 1'b0);
    ext_low = 1'b0; edges(1);
    chk(test, 1'b1);
    $display("test strap done");
    stop_test();
  end
endmodule : power_on_reset_sequencer_tb
